// *** rtl/tct_params.svh ***
// constants shared by both ends of the hint and credit status link
`ifndef TCT_PARAMS_SVH
`define TCT_PARAMS_SVH

// ---------------------------------------------------------------
// widths of the mirrored hint settings
// ---------------------------------------------------------------
`define TCT_NUM_PF      4
`define TCT_NUM_VF      252
`define TCT_MODE_W      3
`define TCT_PF_MODE_W   12
`define TCT_VF_MODE_W   756

// ---------------------------------------------------------------
// layout of a function's requester control word
// ---------------------------------------------------------------
`define TCT_CTRL_W      9
`define TCT_EN_BIT      8
`define TCT_MODE_LSB    0

// ---------------------------------------------------------------
// availability counts and their lag
// ---------------------------------------------------------------
`define TCT_CNT_W       4
`define TCT_CNT_MAX     4'hF
`define TCT_LAG_CYC     8
`define TCT_POOL_W      8
`define TCT_HDR_INIT    8'h20
`define TCT_PLD_INIT    8'h40
`define TCT_TAG_INIT    8'h20

// ---------------------------------------------------------------
// user end register map (byte offsets) and fields
// ---------------------------------------------------------------
`define TCT_ADDR_W      4
`define TCT_REG_REQ     4'h0
`define TCT_REG_STAT    4'h4
`define TCT_REG_SENT    4'h8
`define TCT_REG_PFHINT  4'hC
`define TCT_REQ_GO_BIT  8
`define TCT_REQ_PEND_BIT 8

`endif

// *** rtl/tct_pkg.sv ***
// types shared by both ends of the hint and credit status link
package tct_pkg;
  typedef logic [3:0] tct_avail_t;
  typedef logic [7:0] tct_pool_t;
  typedef logic [2:0] tct_mode_t;
  typedef logic [7:0] tct_recent_t;
endpackage

// *** rtl/tct_if.sv ***
// link between the status block and the requesting user logic
`timescale 1ns/1ns
`include "tct_params.svh"
interface tct_if;
  // mirrored hint settings
  logic [`TCT_PF_MODE_W-1:0] pfSteerModeOut;
  logic [`TCT_NUM_PF-1:0]    pfHintReqEnOut;
  logic [`TCT_NUM_VF-1:0]    vfnHintReqEnOut;
  logic [`TCT_VF_MODE_W-1:0] vfnSteerModeOut;
  // availability counts
  logic [`TCT_CNT_W-1:0]     npHeaderCreditAvail;
  logic [`TCT_CNT_W-1:0]     npPayloadCreditAvail;
  logic [`TCT_CNT_W-1:0]     freeRequestTagCount;
  // non-posted requests
  logic                      reqValid;
  logic                      reqReady;
  logic [`TCT_CNT_W-1:0]     reqPayload;

  modport dev (
    output pfSteerModeOut,
    output pfHintReqEnOut,
    output vfnHintReqEnOut,
    output vfnSteerModeOut,
    output npHeaderCreditAvail,
    output npPayloadCreditAvail,
    output freeRequestTagCount,
    output reqReady,
    input  reqValid,
    input  reqPayload
  );

  modport usr (
    input  pfSteerModeOut,
    input  pfHintReqEnOut,
    input  vfnHintReqEnOut,
    input  vfnSteerModeOut,
    input  npHeaderCreditAvail,
    input  npPayloadCreditAvail,
    input  freeRequestTagCount,
    input  reqReady,
    output reqValid,
    output reqPayload
  );
endinterface

// *** rtl/tct_device.sv ***
// device end: hint setting mirrors and lagged credit and tag counts
`timescale 1ns/1ns
`include "tct_params.svh"
module tct_device
  import tct_pkg::*;
#(
  parameter int LAG = `TCT_LAG_CYC
) (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst,
  // link toward the user logic
  tct_if.dev                          link,
  // configuration writes into the requester control words
  input  wire logic                   cfgWe,
  input  wire logic                   cfgIsVf,
  input  wire logic [7:0]             cfgFunc,
  input  wire logic [`TCT_CTRL_W-1:0] cfgData,
  // credit and tag returns from the far side of the link
  input  wire logic                   hdrReturn,
  input  wire logic [`TCT_CNT_W-1:0]  pldReturn,
  input  wire logic                   tagReturn,
  // true pool levels, unlagged
  output logic [`TCT_POOL_W-1:0]      hdrPoolLevel,
  output logic [`TCT_POOL_W-1:0]      pldPoolLevel,
  output logic [`TCT_POOL_W-1:0]      tagPoolLevel
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // clamp a pool level into the four-bit report
  function automatic tct_avail_t satCount(input tct_pool_t lvl);
    if (lvl > tct_pool_t'(`TCT_CNT_MAX)) begin
      satCount = `TCT_CNT_MAX;
    end else begin
      satCount = lvl[`TCT_CNT_W-1:0];
    end
  endfunction

  // ---------------------------------------------------------------
  // mirrored requester control fields
  // ---------------------------------------------------------------
  logic [`TCT_NUM_PF-1:0]    pfEn;
  logic [`TCT_PF_MODE_W-1:0] pfMode;
  logic [`TCT_NUM_VF-1:0]    vfEn;
  logic [`TCT_VF_MODE_W-1:0] vfMode;

  // write decode: functions past the implemented range are dropped
  wire       pfHit   = cfgWe && !cfgIsVf
                       && (cfgFunc < 8'(`TCT_NUM_PF));
  wire       vfHit   = cfgWe && cfgIsVf
                       && (cfgFunc < 8'(`TCT_NUM_VF));
  wire       newEn   = cfgData[`TCT_EN_BIT];
  wire tct_mode_t newMode =
    cfgData[`TCT_MODE_LSB +: `TCT_MODE_W];
  wire [1:0] pfIdx   = cfgFunc[1:0];

  // physical function words
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pfEn   <= '0;
      pfMode <= '0;
    end else if (pfHit) begin
      pfEn[pfIdx]                           <= newEn;
      pfMode[pfIdx*`TCT_MODE_W +: `TCT_MODE_W] <= newMode;
    end
  end

  // virtual function words
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      vfEn   <= '0;
      vfMode <= '0;
    end else if (vfHit) begin
      vfEn[cfgFunc]                            <= newEn;
      vfMode[cfgFunc*`TCT_MODE_W +: `TCT_MODE_W] <= newMode;
    end
  end

  // mirrors come straight from flops, so they only move on a write
  assign link.pfHintReqEnOut  = pfEn;
  assign link.pfSteerModeOut  = pfMode;
  assign link.vfnHintReqEnOut = vfEn;
  assign link.vfnSteerModeOut = vfMode;

  // ---------------------------------------------------------------
  // credit and tag pools
  // ---------------------------------------------------------------
  tct_pool_t hdrPool;
  tct_pool_t pldPool;
  tct_pool_t tagPool;
  tct_pool_t next_hdrPool;
  tct_pool_t next_pldPool;
  tct_pool_t next_tagPool;

  // the request port blocks whenever the true pools cannot cover it
  wire tct_pool_t pldNeed = tct_pool_t'(link.reqPayload);
  wire hdrOk  = (hdrPool != '0);
  wire pldOk  = (pldPool >= pldNeed);
  wire tagOk  = (tagPool != '0);
  assign link.reqReady = hdrOk && pldOk && tagOk;
  wire take   = link.reqValid && link.reqReady;

  // next levels: a take and a return in one cycle both count
  always_comb begin
    next_hdrPool = hdrPool;
    next_pldPool = pldPool;
    next_tagPool = tagPool;
    if (take) begin
      next_hdrPool = next_hdrPool - 8'h01;
      next_pldPool = next_pldPool - pldNeed;
      next_tagPool = next_tagPool - 8'h01;
    end
    if (hdrReturn) begin
      next_hdrPool = next_hdrPool + 8'h01;
    end
    next_pldPool = next_pldPool + tct_pool_t'(pldReturn);
    if (tagReturn) begin
      next_tagPool = next_tagPool + 8'h01;
    end
  end

  // pool registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hdrPool <= `TCT_HDR_INIT;
      pldPool <= `TCT_PLD_INIT;
      tagPool <= `TCT_TAG_INIT;
    end else begin
      hdrPool <= next_hdrPool;
      pldPool <= next_pldPool;
      tagPool <= next_tagPool;
    end
  end

  assign hdrPoolLevel = hdrPool;
  assign pldPoolLevel = pldPool;
  assign tagPoolLevel = tagPool;

  // ---------------------------------------------------------------
  // report pipeline
  // ---------------------------------------------------------------
  // models the status path latency: the reported counts show the
  // pools as they stood LAG cycles ago, so the newest takes are
  // missing and the user end has to correct for them
  tct_pool_t hdrLag [LAG-1];
  tct_pool_t pldLag [LAG-1];
  tct_pool_t tagLag [LAG-1];

  // delay stages, all seeded with the reset levels
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < LAG-1; i++) begin
        hdrLag[i] <= `TCT_HDR_INIT;
        pldLag[i] <= `TCT_PLD_INIT;
        tagLag[i] <= `TCT_TAG_INIT;
      end
    end else begin
      hdrLag[0] <= hdrPool;
      pldLag[0] <= pldPool;
      tagLag[0] <= tagPool;
      for (int i = 1; i < LAG-1; i++) begin
        hdrLag[i] <= hdrLag[i-1];
        pldLag[i] <= pldLag[i-1];
        tagLag[i] <= tagLag[i-1];
      end
    end
  end

  // ---------------------------------------------------------------
  // saturated reports
  // ---------------------------------------------------------------
  tct_avail_t hdrRep;
  tct_avail_t pldRep;
  tct_avail_t tagRep;

  // last stage; exactly fourteen reads as 1110 and above as 1111
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hdrRep <= `TCT_CNT_MAX; // every pool starts above fifteen
      pldRep <= `TCT_CNT_MAX;
      tagRep <= `TCT_CNT_MAX;
    end else begin
      hdrRep <= satCount(hdrLag[LAG-2]);
      pldRep <= satCount(pldLag[LAG-2]);
      tagRep <= satCount(tagLag[LAG-2]);
    end
  end

  // reports stay put between clock edges
  assign link.npHeaderCreditAvail  = hdrRep;
  assign link.npPayloadCreditAvail = pldRep;
  assign link.freeRequestTagCount  = tagRep;

endmodule

// *** rtl/tct_user.sv ***
// user end: issues non-posted requests against corrected counts
`timescale 1ns/1ns
`include "tct_params.svh"
module tct_user
  import tct_pkg::*;
#(
  parameter int LAG = `TCT_LAG_CYC
) (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst,
  // link toward the device
  tct_if.usr                          link,
  // software register port
  input  wire logic [`TCT_ADDR_W-1:0] addr,
  input  wire logic [31:0]            wrData,
  input  wire logic                   wrEn,
  input  wire logic                   rdEn,
  output logic [31:0]                 rdData
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // subtract recent use, never going below zero
  function automatic tct_avail_t floorSub(input tct_avail_t a,
                                          input tct_recent_t b);
    if (tct_recent_t'(a) > b) begin
      floorSub = a - b[`TCT_CNT_W-1:0];
    end else begin
      floorSub = '0;
    end
  endfunction

  // ---------------------------------------------------------------
  // history of the last LAG cycles
  // ---------------------------------------------------------------
  logic       histReq [LAG];
  tct_avail_t histPld [LAG];
  logic       pending;
  tct_avail_t reqPld;
  logic [15:0] sentCount;

  wire take = link.reqValid && link.reqReady;

  // slot 0 is last cycle, slot LAG-1 is LAG cycles back
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < LAG; i++) begin
        histReq[i] <= 1'b0;
        histPld[i] <= '0;
      end
    end else begin
      histReq[0] <= take;
      histPld[0] <= take ? reqPld : 4'h0;
      for (int i = 1; i < LAG; i++) begin
        histReq[i] <= histReq[i-1];
        histPld[i] <= histPld[i-1];
      end
    end
  end

  // sums of what the device counts do not yet show
  tct_recent_t recentReq;
  tct_recent_t recentPld;
  always_comb begin
    recentReq = '0;
    recentPld = '0;
    for (int i = 0; i < LAG; i++) begin
      recentReq = recentReq + tct_recent_t'(histReq[i]);
      recentPld = recentPld + tct_recent_t'(histPld[i]);
    end
  end

  // ---------------------------------------------------------------
  // corrected availability and issue decision
  // ---------------------------------------------------------------
  wire tct_avail_t corrHdr =
    floorSub(link.npHeaderCreditAvail, recentReq);
  wire tct_avail_t corrPld =
    floorSub(link.npPayloadCreditAvail, recentPld);
  wire tct_avail_t corrTag =
    floorSub(link.freeRequestTagCount, recentReq);

  // only offer when credit and a tag are known free
  wire canSend = pending && (corrHdr != '0)
                 && (corrPld >= reqPld)
                 && (corrTag != '0);
  assign link.reqValid   = canSend;
  assign link.reqPayload = reqPld;

  // ---------------------------------------------------------------
  // request register
  // ---------------------------------------------------------------
  wire reqWr = wrEn && (addr == `TCT_REG_REQ);
  wire goWr  = reqWr && wrData[`TCT_REQ_GO_BIT];

  // a new order in the same cycle as a take wins over the clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pending   <= 1'b0;
      reqPld    <= '0;
      sentCount <= '0;
    end else begin
      if (goWr) begin
        pending <= 1'b1;
        reqPld  <= wrData[`TCT_CNT_W-1:0];
      end else if (take) begin
        pending <= 1'b0;
      end
      if (take) begin
        sentCount <= sentCount + 16'h0001;
      end
    end
  end

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  wire [31:0] rdReq  = {23'h0, pending, 4'h0, reqPld};
  wire [31:0] rdStat = {20'h0, corrTag, corrPld, corrHdr};
  wire [31:0] rdSent = {16'h0, sentCount};
  wire [31:0] rdPf   = {16'h0, link.pfSteerModeOut,
                        link.pfHintReqEnOut};
  wire [31:0] rdSel  =
    (addr == `TCT_REG_REQ)    ? rdReq  :
    (addr == `TCT_REG_STAT)   ? rdStat :
    (addr == `TCT_REG_SENT)   ? rdSent :
    (addr == `TCT_REG_PFHINT) ? rdPf   : 32'h0;

  // data stand for one cycle after the strobe, zero otherwise
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdData <= 32'h0;
    end else begin
      rdData <= rdEn ? rdSel : 32'h0;
    end
  end

endmodule

// *** verif/tct_link_chk.sv ***
// checker for the status link: count lag, saturation, request gating
`timescale 1ns/1ns
`include "tct_params.svh"
module tct_link_chk
#(
  parameter int LAG = `TCT_LAG_CYC
) (
  // clock and reset
  input wire logic                  clk,
  input wire logic                  rst,
  // availability counts
  input wire logic [`TCT_CNT_W-1:0] npHeaderCreditAvail,
  input wire logic [`TCT_CNT_W-1:0] npPayloadCreditAvail,
  input wire logic [`TCT_CNT_W-1:0] freeRequestTagCount,
  // request handshake
  input wire logic                  reqValid,
  input wire logic                  reqReady,
  input wire logic [`TCT_CNT_W-1:0] reqPayload
);
  // ---------------------------------------------------------------
  // helper terms
  // ---------------------------------------------------------------
  // a take reaches the counts one pool cycle plus the lag later
  localparam int D = LAG + 1;
  wire take = reqValid && reqReady;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  // header and tag counts sit at full scale while reset is held
  reset_counts_a: assert property (disable iff (1'b0) rst |->
    npHeaderCreditAvail == 4'hF && freeRequestTagCount == 4'hF)
    else $error("counts not full in reset");
  // returns only raise counts, so any fall needs an old take
  hdr_drop_cause_a: assert property (
    npHeaderCreditAvail < $past(npHeaderCreditAvail) |-> $past(take, D))
    else $error("header count fell without a lagged take");
  hdr_drop_one_a: assert property (
    npHeaderCreditAvail < $past(npHeaderCreditAvail) |->
    npHeaderCreditAvail == $past(npHeaderCreditAvail) - 4'h1)
    else $error("header count fell by more than one");
  tag_drop_cause_a: assert property (
    freeRequestTagCount < $past(freeRequestTagCount) |-> $past(take, D))
    else $error("tag count fell without a lagged take");
  tag_drop_one_a: assert property (
    freeRequestTagCount < $past(freeRequestTagCount) |->
    freeRequestTagCount == $past(freeRequestTagCount) - 4'h1)
    else $error("tag count fell by more than one");
  pld_drop_bound_a: assert property (
    npPayloadCreditAvail < $past(npPayloadCreditAvail) |-> $past(take, D)
    && $past(npPayloadCreditAvail) - npPayloadCreditAvail
       <= $past(reqPayload, D))
    else $error("payload count fell beyond lagged request");
  // corrected counts never exceed the lagged ones
  gate_hdr_tag_a: assert property (reqValid |->
    npHeaderCreditAvail != 4'h0 && freeRequestTagCount != 4'h0)
    else $error("request offered with no header or tag");
  gate_payload_a: assert property (
    reqValid |-> reqPayload <= npPayloadCreditAvail)
    else $error("request offered beyond payload count");

  // main scenarios
  cover property (take);
  cover property (npPayloadCreditAvail == 4'hE);
  cover property (freeRequestTagCount == 4'h0);
endmodule

// *** verif/tb_tph_credit_tag_status.sv ***
// self-checking bench: both ends joined, mirrors and counts
`timescale 1ns/1ns
`include "tct_params.svh"
module tb_tph_credit_tag_status;
  // ---------------------------------------------------------------
  // stimulus and observed signals
  // ---------------------------------------------------------------
  logic                    clk;
  logic                    rst;
  logic                    cfgWe;
  logic                    cfgIsVf;
  logic [7:0]              cfgFunc;
  logic [`TCT_CTRL_W-1:0]  cfgData;
  logic                    hdrReturn;
  logic [`TCT_CNT_W-1:0]   pldReturn;
  logic                    tagReturn;
  logic [`TCT_POOL_W-1:0]  hdrPoolLevel;
  logic [`TCT_POOL_W-1:0]  pldPoolLevel;
  logic [`TCT_POOL_W-1:0]  tagPoolLevel;
  logic [`TCT_ADDR_W-1:0]  addr;
  logic [31:0]             wrData;
  logic                    wrEn;
  logic                    rdEn;
  logic [31:0]             rdData;
  int                      nFail;
  int                      checked;

  tct_if link ();
  tct_device #(.LAG(`TCT_LAG_CYC)) u_tct_device (.clk, .rst, .link,
    .cfgWe, .cfgIsVf, .cfgFunc, .cfgData, .hdrReturn, .pldReturn,
    .tagReturn, .hdrPoolLevel, .pldPoolLevel, .tagPoolLevel);
  tct_user #(.LAG(`TCT_LAG_CYC)) u_tct_user (.clk, .rst, .link,
    .addr, .wrData, .wrEn, .rdEn, .rdData);
  tct_link_chk #(.LAG(`TCT_LAG_CYC)) u_tct_link_chk (.clk, .rst,
    .npHeaderCreditAvail  (link.npHeaderCreditAvail),
    .npPayloadCreditAvail (link.npPayloadCreditAvail),
    .freeRequestTagCount  (link.freeRequestTagCount),
    .reqValid             (link.reqValid),
    .reqReady             (link.reqReady),
    .reqPayload           (link.reqPayload));

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  // free-running 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic tally_and_finish();
    if (nFail == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      nFail++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  // waits end just past an edge so outputs have settled
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr   <= a;
    wrData <= d;
    wrEn   <= 1'b1;
    @(posedge clk);
    wrEn   <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rdEn <= 1'b1;
    @(posedge clk);
    rdEn <= 1'b0;
    #1 d = rdData;
  endtask

  task automatic rdChk(input logic [3:0] a, input logic [31:0] e,
                       input string n);
    logic [31:0] d;
    rd(a, d);
    chk(n, e, d);
  endtask

  task automatic cfg(input logic v, input logic [7:0] f,
                     input logic [8:0] d);
    @(posedge clk);
    cfgWe   <= 1'b1;
    cfgIsVf <= v;
    cfgFunc <= f;
    cfgData <= d;
    @(posedge clk);
    cfgWe   <= 1'b0;
  endtask

  // bounded poll of the accepted-request counter
  task automatic waitSent(input logic [15:0] n);
    logic [31:0] d;
    for (int i = 0; i < 60; i++) begin
      rd(`TCT_REG_SENT, d);
      if (d[15:0] === n) return;
    end
    nFail++;
    $display("mismatch sent count expected %0d seen %0d", n, d[15:0]);
    tally_and_finish();
  endtask

  task automatic req(input logic [3:0] p, input logic [15:0] n);
    wr(`TCT_REG_REQ, {23'h000000, 1'b1, 4'h0, p});
    waitSent(n);
  endtask

  task automatic cnt(input logic [11:0] e);
    chk("link counts", {20'h00000, e}, {20'h00000,
      link.freeRequestTagCount, link.npPayloadCreditAvail,
      link.npHeaderCreditAvail});
  endtask

  task automatic pools(input logic [23:0] e);
    chk("pools", {8'h00, e}, {8'h00, tagPoolLevel, pldPoolLevel,
      hdrPoolLevel});
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    rst = 1'b1;
    {cfgWe, cfgIsVf, cfgFunc, cfgData} = '0;
    {hdrReturn, pldReturn, tagReturn} = '0;
    {addr, wrData, wrEn, rdEn} = '0;
    nFail = 0;
    checked = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    idle(1);
    cnt(12'hFFF);
    rdChk(`TCT_REG_STAT, 32'h00000FFF, "stat");
    rdChk(4'h2, 32'h0, "unmapped");
    // every mode code once, enables on odd functions
    for (int i = 0; i < 8; i++) cfg(1'b1, i[7:0], {i[0], 5'h00, i[2:0]});
    cfg(1'b1, 8'd251, 9'h105);
    cfg(1'b1, 8'd252, 9'h107);
    cfg(1'b0, 8'h00, 9'h105);
    cfg(1'b0, 8'h01, 9'h003);
    cfg(1'b0, 8'h04, 9'h107);
    idle(1);
    chk("pf mode", 32'h1D, link.pfSteerModeOut);
    chk("pf en", 32'h1, link.pfHintReqEnOut);
    chk("vf en low", 32'hAA, link.vfnHintReqEnOut[31:0]);
    chk("vf en top", 32'h80000000, link.vfnHintReqEnOut[251:220]);
    chk("vf mode low", 32'hFAC688, link.vfnSteerModeOut[31:0]);
    chk("vf mode top", 32'hA0000000, link.vfnSteerModeOut[755:724]);
    rdChk(`TCT_REG_PFHINT, 32'h01D1, "pf hint reg");
    // drain pools until header and tag counts leave saturation
    for (int i = 1; i <= 20; i++) req(4'h2, i[15:0]);
    idle(10);
    cnt(12'hCFC);
    pools(24'h0C180C);
    // lagged count still old while corrected one is new
    req(4'hA, 16'd21);
    cnt(12'hCFC);
    rdChk(`TCT_REG_STAT, 32'h0B5B, "stat corrected");
    idle(10);
    cnt(12'hBEB);
    @(posedge clk);
    pldReturn <= 4'h1;
    @(posedge clk);
    pldReturn <= 4'h0;
    idle(10);
    cnt(12'hBFB);
    for (int i = 22; i <= 32; i++) req(4'h0, i[15:0]);
    idle(10);
    cnt(12'h0F0);
    // no header or tag left: request must wait
    wr(`TCT_REG_REQ, 32'h101);
    idle(12);
    chk("ready held", 32'h0, link.reqReady);
    chk("valid held", 32'h0, link.reqValid);
    rdChk(`TCT_REG_SENT, 32'd32, "sent held");
    rdChk(`TCT_REG_REQ, 32'h101, "pending");
    @(posedge clk);
    hdrReturn <= 1'b1;
    tagReturn <= 1'b1;
    @(posedge clk);
    hdrReturn <= 1'b0;
    tagReturn <= 1'b0;
    waitSent(16'd33);
    pools(24'h000E00);
    tally_and_finish();
  end
endmodule
